// file: vlb_vout_limit_bank.sv
// Output-voltage warning and fault limit commands with status and fault response
`timescale 1ns/10ps
// How it works
// - Overvoltage warning 103-116 percent, round up.
// - Convert written value per output format.
// - Under-voltage warning 84-97 percent, round down.
// - Under-voltage fault 60-95 percent, 2.5 steps.
// - Thresholds follow the present voltage target.
// - Target change leaves stored limits unchanged.
// - Unsupported write flags invalid data, notifies.
// - Under-voltage warning sets status, notifies host.
// - Under-voltage fault acts per action byte.
// - Under-voltage fault sets three status bits.
// - Action bits: ignore, delayed, immediate, invalid.
// - Restart count: latch, limited, or forever.
// - Delay bits pick shutdown delay, restart wait.
module vlb_vout_limit_bank #(
  parameter int RISE_CYC = vlb_pkg::SOFT_START_RISE_CYC
) (
  input  wire logic                 mclk_i,          // 50 MHz clock
  input  wire logic                 rst_n_i,         // Async reset, active low
  input  wire vlb_pkg::vlb_cmd_t    cmd_i,           // Decoded command request
  output logic [15:0]               cmd_rdata_o,     // Read data word
  output logic                      cmd_ack_o,       // Command taken, one cycle
  input  wire logic                 format_abs_i,    // Absolute output format
  input  wire logic [15:0]          vout_command_i,  // Output voltage target
  input  wire logic [15:0]          vout_sense_i,    // Sensed output voltage
  input  wire logic                 clear_faults_i,  // Clear sticky status
  input  wire logic                 output_on_i,     // Output commanded on
  input  wire logic                 pwm_tick_i,      // Switching clock pulse
  output vlb_pkg::vlb_status_t      status_o,        // Sticky status bits
  output logic                      alert_n_o,       // Host notify, active low
  output logic                      shutdown_o,      // Output forced off
  output logic                      latched_o        // Latched off
);

  typedef struct packed {
    logic [15:0]          ov_warning_value;
    logic [15:0]          uv_warning_flag_or_value;
    logic [15:0]          uv_fault_flag_or_value;
    logic [7:0]           action;
    logic [3:0]           ovw_idx;
    logic [3:0]           uvw_idx;
    logic [3:0]           uvf_idx;
    vlb_pkg::vlb_status_t sts;
    logic [15:0]          rdata;
    logic                 ack;
  } vlb_bank_state_t;

  vlb_bank_state_t q, next_q;

  // ==========================================================================
  // Mapping helpers

  // Returns {valid, step}: the hardware step matching val against ref_v
  function automatic logic [4:0] map_pct(input logic [15:0] val,
                                         input logic [15:0] ref_v,
                                         input logic [10:0] pmin,
                                         input logic [10:0] pstep,
                                         input logic [3:0]  n,
                                         input logic        up);
    logic [31:0] scaled;
    logic [31:0] p;
    logic [31:0] lo;
    logic [31:0] hi;
    logic        found;
    logic [3:0]  idx;
    scaled = 32'(val) * 32'(vlb_pkg::PCT_FULL);
    lo     = 32'(ref_v) * 32'(pmin);
    hi     = 32'(ref_v) * 32'(11'(pmin + 11'(n - 4'h1) * pstep));
    found  = 1'b0;
    idx    = 4'h0;
    for (int k = 0; k < 16; k++) begin
      p = 32'(ref_v) * 32'(11'(pmin + 11'(k) * pstep));
      if (4'(k) < n) begin
        if (up && !found && (p >= scaled)) begin
          found = 1'b1;
          idx   = 4'(k);
        end
        if (!up && (p <= scaled)) begin
          found = 1'b1;
          idx   = 4'(k);
        end
      end
    end
    // Anything outside the supported span is refused, not clamped
    map_pct = {found && (ref_v != 16'h0000) && (scaled >= lo) && (scaled <= hi), idx};
  endfunction

  // Threshold voltage for a stored step, on the present target
  function automatic logic [15:0] thr(input logic [15:0] tgt,
                                      input logic [10:0] pmin,
                                      input logic [10:0] pstep,
                                      input logic [3:0]  idx);
    thr = 16'((32'(tgt) * 32'(11'(pmin + 11'(idx) * pstep))) / 32'(vlb_pkg::PCT_FULL));
  endfunction

  // ==========================================================================
  // Write decode and thresholds

  logic [15:0] ref_v;
  logic [4:0]  ovw_map;
  logic [4:0]  uvw_map;
  logic [4:0]  uvf_map;
  logic [15:0] ovw_thr;
  logic [15:0] uvw_thr;
  logic [15:0] uvf_thr;
  logic        ovw_evt;
  logic        uvw_evt;
  logic        uvf_evt;
  logic        bad_wr;

  assign ref_v = format_abs_i ? vout_command_i : vlb_pkg::REL_UNITY;

  assign ovw_map = map_pct(cmd_i.wdata, ref_v, vlb_pkg::OVW_MIN, vlb_pkg::OVW_STEP,
                           vlb_pkg::OVW_N, 1'b1);
  assign uvw_map = map_pct(cmd_i.wdata, ref_v, vlb_pkg::UVW_MIN, vlb_pkg::UVW_STEP,
                           vlb_pkg::UVW_N, 1'b0);
  assign uvf_map = map_pct(cmd_i.wdata, ref_v, vlb_pkg::UVF_MIN, vlb_pkg::UVF_STEP,
                           vlb_pkg::UVF_N, 1'b0);

  assign ovw_thr = thr(vout_command_i, vlb_pkg::OVW_MIN, vlb_pkg::OVW_STEP, q.ovw_idx);
  assign uvw_thr = thr(vout_command_i, vlb_pkg::UVW_MIN, vlb_pkg::UVW_STEP, q.uvw_idx);
  assign uvf_thr = thr(vout_command_i, vlb_pkg::UVF_MIN, vlb_pkg::UVF_STEP, q.uvf_idx);

  assign uvw_evt = vout_sense_i < uvw_thr;
  assign uvf_evt = vout_sense_i < uvf_thr;
  assign ovw_evt = vout_sense_i > ovw_thr;

  always_comb begin
    case (cmd_i.code)
      vlb_pkg::CMD_OV_WARN:  bad_wr = cmd_i.wr && !ovw_map[4];
      vlb_pkg::CMD_UV_WARN:  bad_wr = cmd_i.wr && !uvw_map[4];
      vlb_pkg::CMD_UV_FAULT: bad_wr = cmd_i.wr && !uvf_map[4];
      vlb_pkg::CMD_UV_RESP:  bad_wr = cmd_i.wr &&
        (cmd_i.wdata[vlb_pkg::ACT_HI:vlb_pkg::ACT_LO] > vlb_pkg::ACT_NOW);
      default:               bad_wr = 1'b0;
    endcase
  end

  // ==========================================================================
  // Next state

  always_comb begin
    next_q     = q;
    next_q.ack = 1'b0;
    if (cmd_i.wr && !bad_wr) begin
      // only a write moves a limit
      case (cmd_i.code)
        vlb_pkg::CMD_OV_WARN: begin
          next_q.ov_warning_value = cmd_i.wdata;
          next_q.ovw_idx          = ovw_map[3:0];
        end
        vlb_pkg::CMD_UV_WARN: begin
          next_q.uv_warning_flag_or_value = cmd_i.wdata;
          next_q.uvw_idx                  = uvw_map[3:0];
        end
        vlb_pkg::CMD_UV_FAULT: begin
          next_q.uv_fault_flag_or_value = cmd_i.wdata;
          next_q.uvf_idx                = uvf_map[3:0];
        end
        vlb_pkg::CMD_UV_RESP: next_q.action = cmd_i.wdata[7:0];
        default: next_q.action = q.action;
      endcase
    end
    if (cmd_i.rd) begin
      case (cmd_i.code)
        vlb_pkg::CMD_OV_WARN:  next_q.rdata = q.ov_warning_value;
        vlb_pkg::CMD_UV_WARN:  next_q.rdata = q.uv_warning_flag_or_value;
        vlb_pkg::CMD_UV_FAULT: next_q.rdata = q.uv_fault_flag_or_value;
        vlb_pkg::CMD_UV_RESP:  next_q.rdata = {8'h00, q.action};
        default:               next_q.rdata = 16'h0000;
      endcase
    end
    case (cmd_i.code)
      vlb_pkg::CMD_OV_WARN, vlb_pkg::CMD_UV_WARN,
      vlb_pkg::CMD_UV_FAULT, vlb_pkg::CMD_UV_RESP: next_q.ack = cmd_i.wr || cmd_i.rd;
      default: next_q.ack = 1'b0;
    endcase
    // Clear first, then set, so an event in the clearing cycle survives
    if (clear_faults_i) begin
      next_q.sts = '0;
    end
    next_q.sts.cml_invalid = next_q.sts.cml_invalid | bad_wr;
    next_q.sts.ov_warning  = next_q.sts.ov_warning | ovw_evt;
    next_q.sts.uv_warning  = next_q.sts.uv_warning | uvw_evt;
    next_q.sts.uv_fault    = next_q.sts.uv_fault | uvf_evt;
    next_q.sts.none_above  = next_q.sts.none_above | uvf_evt;
    next_q.sts.vout_word   = next_q.sts.vout_word | ovw_evt | uvw_evt | uvf_evt;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{ov_warning_value: vlb_pkg::OVW_RST_RAW,
             uv_warning_flag_or_value: vlb_pkg::UVW_RST_RAW,
             uv_fault_flag_or_value: vlb_pkg::UVF_RST_RAW,
             action: vlb_pkg::RESP_RST,
             ovw_idx: vlb_pkg::OVW_RST_IDX,
             uvw_idx: vlb_pkg::UVW_RST_IDX,
             uvf_idx: vlb_pkg::UVF_RST_IDX,
             sts: '0, rdata: 16'h0000, ack: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign cmd_rdata_o = q.rdata;
  assign cmd_ack_o   = q.ack;
  assign status_o    = q.sts;
  assign alert_n_o   = ~(|q.sts);

  vlb_uv_responder #(
    .RISE_CYC (RISE_CYC)
  ) u_resp (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .fault_i     (uvf_evt),
    .action_i    (q.action),
    .pwm_tick_i  (pwm_tick_i),
    .output_on_i (output_on_i),
    .shutdown_o  (shutdown_o),
    .latched_o   (latched_o)
  );

  // ==========================================================================
  // Checks

  AST_BAD_ACTION_KEPT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmd_i.wr && (cmd_i.code == vlb_pkg::CMD_UV_RESP) && (cmd_i.wdata[7:6] == 2'h3)
    |=> (q.action == $past(q.action)) && status_o.cml_invalid && !alert_n_o)
    else $error("Invalid action byte accepted");

  AST_UVW_FLAGS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (vout_sense_i < uvw_thr) |=> status_o.uv_warning && status_o.vout_word && !alert_n_o)
    else $error("Under-voltage warning status missing");

  AST_UVF_FLAGS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    uvf_evt |=> status_o.uv_fault && status_o.none_above && status_o.vout_word)
    else $error("Under-voltage fault status missing");

  AST_OVW_SPAN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    q.ovw_idx < vlb_pkg::OVW_N)
    else $error("Overvoltage warning step out of span");

  AST_UVF_SPAN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    q.uvf_idx < vlb_pkg::UVF_N)
    else $error("Under-voltage fault step out of span");

  AST_TARGET_KEEPS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $changed(vout_command_i) && !cmd_i.wr |=> $stable(q.uv_warning_flag_or_value) &&
    $stable(q.uv_fault_flag_or_value) && $stable(q.uvw_idx) && $stable(q.uvf_idx))
    else $error("Target change altered a stored limit");

  AST_UVW_BELOW: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    uvw_thr < vout_command_i || vout_command_i == 16'h0000)
    else $error("Warning threshold not below target");

  AST_REL_ROUND_UP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmd_i.wr && !format_abs_i && (cmd_i.code == vlb_pkg::CMD_OV_WARN) &&
    (cmd_i.wdata == 16'h0210) |=> (q.ovw_idx == 4'h1) ##1 (q.ov_warning_value != 16'h0000))
    else $error("Relative warning value mapped wrongly");

endmodule

// file: vlb_pkg.sv
// Constants and carrier types for the output-voltage limit command bank
package vlb_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_OV_WARN  = 8'h42;
  localparam logic [7:0] CMD_UV_WARN  = 8'h43;
  localparam logic [7:0] CMD_UV_FAULT = 8'h44;
  localparam logic [7:0] CMD_UV_RESP  = 8'h45;

  // ==========================================================================
  // Percentages in tenths of a percent
  localparam logic [10:0] PCT_FULL  = 11'h3e8;   // 100.0 %
  localparam logic [10:0] OVW_MIN   = 11'h406;   // 103.0 %
  localparam logic [10:0] OVW_STEP  = 11'h00a;   // 1.0 %
  localparam logic [3:0]  OVW_N     = 4'he;      // 103..116
  localparam logic [10:0] UVW_MIN   = 11'h348;   // 84.0 %
  localparam logic [10:0] UVW_STEP  = 11'h00a;   // 1.0 %
  localparam logic [3:0]  UVW_N     = 4'he;      // 84..97
  localparam logic [10:0] UVF_MIN   = 11'h258;   // 60.0 %
  localparam logic [10:0] UVF_STEP  = 11'h019;   // 2.5 %
  localparam logic [3:0]  UVF_N     = 4'hf;      // 60..95
  // Relative format: this code means 100 % of the target
  localparam logic [15:0] REL_UNITY = 16'h0200;

  // ==========================================================================
  // Reset values (raw words and the hardware step they map to)
  localparam logic [15:0] OVW_RST_RAW = 16'h0240;  // 112.5 % -> 113 %
  localparam logic [3:0]  OVW_RST_IDX = 4'ha;
  localparam logic [15:0] UVW_RST_RAW = 16'h01c0;  // 87.5 % -> 87 %
  localparam logic [3:0]  UVW_RST_IDX = 4'h3;
  localparam logic [15:0] UVF_RST_RAW = 16'h0180;  // 75 %
  localparam logic [3:0]  UVF_RST_IDX = 4'h6;
  localparam logic [7:0]  RESP_RST    = 8'h80;     // Shut down at once, latch

  // ==========================================================================
  // Fault action byte fields
  localparam int          ACT_HI      = 7;
  localparam int          ACT_LO      = 6;
  localparam int          RETRY_HI    = 5;
  localparam int          RETRY_LO    = 3;
  localparam int          DLY_HI      = 2;
  localparam int          DLY_LO      = 0;
  localparam logic [1:0]  ACT_IGNORE  = 2'h0;
  localparam logic [1:0]  ACT_DELAYED = 2'h1;
  localparam logic [1:0]  ACT_NOW     = 2'h2;
  localparam logic [2:0]  RETRY_NONE  = 3'h0;
  localparam logic [2:0]  RETRY_EVER  = 3'h7;
  localparam logic [2:0]  DLY_SHORT   = 3'h1;
  localparam logic [2:0]  DLY_MID     = 3'h4;
  localparam logic [2:0]  PWM_DLY_S   = 3'h1;
  localparam logic [2:0]  PWM_DLY_M   = 3'h3;
  localparam logic [2:0]  PWM_DLY_L   = 3'h7;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ            = 50;
  localparam int SOFT_START_RISE_US = 1000;
  localparam int SOFT_START_RISE_CYC = SOFT_START_RISE_US * CLK_MHZ;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {UV_IDLE, UV_DELAY, UV_OFF, UV_LATCH} vlb_uv_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  code;
    logic [15:0] wdata;
  } vlb_cmd_t;

  typedef struct packed {
    logic none_above;    // Status byte: none of the above
    logic vout_word;     // Status word: output voltage
    logic cml_invalid;   // Communication: invalid data
    logic ov_warning;    // Output status: overvoltage warning
    logic uv_warning;    // Output status: under-voltage warning
    logic uv_fault;      // Output status: under-voltage fault
  } vlb_status_t;

endpackage

// file: vlb_uv_responder.sv
// Under-voltage fault response sequencer: delay, shutdown, restart, latch-off
`timescale 1ns/10ps
module vlb_uv_responder #(
  parameter int RISE_CYC = vlb_pkg::SOFT_START_RISE_CYC
) (
  input  wire logic       mclk_i,       // 50 MHz clock
  input  wire logic       rst_n_i,      // Async reset, active low
  input  wire logic       fault_i,      // Under-voltage below fault threshold
  input  wire logic [7:0] action_i,     // Fault action byte
  input  wire logic       pwm_tick_i,   // One pulse per switching clock
  input  wire logic       output_on_i,  // Output commanded on
  output logic            shutdown_o,   // Output forced off
  output logic            latched_o     // Latched off until commanded off
);

  typedef struct packed {
    vlb_pkg::vlb_uv_state_t st;
    logic [23:0]            cnt;
    logic [2:0]             tries;
  } vlb_rsp_state_t;

  vlb_rsp_state_t q, next_q;

  logic [1:0] undervoltage_action_select;
  logic [2:0] undervoltage_restart_count;
  logic [2:0] undervoltage_delay_select;
  logic [2:0] pwm_delay;
  logic [2:0] restart_mult;
  logic [23:0] restart_wait_period;
  logic        give_up;

  assign undervoltage_action_select = action_i[vlb_pkg::ACT_HI:vlb_pkg::ACT_LO];
  assign undervoltage_restart_count = action_i[vlb_pkg::RETRY_HI:vlb_pkg::RETRY_LO];
  assign undervoltage_delay_select  = action_i[vlb_pkg::DLY_HI:vlb_pkg::DLY_LO];

  always_comb begin
    if (undervoltage_delay_select <= vlb_pkg::DLY_SHORT) begin
      pwm_delay    = vlb_pkg::PWM_DLY_S;
      restart_mult = vlb_pkg::DLY_SHORT;
    end else if (undervoltage_delay_select <= vlb_pkg::DLY_MID) begin
      pwm_delay    = vlb_pkg::PWM_DLY_M;
      restart_mult = undervoltage_delay_select;
    end else begin
      pwm_delay    = vlb_pkg::PWM_DLY_L;
      restart_mult = undervoltage_delay_select;
    end
  end
  assign restart_wait_period = 24'(RISE_CYC * int'(restart_mult));

  assign give_up = (undervoltage_restart_count == vlb_pkg::RETRY_NONE) ||
                   ((undervoltage_restart_count != vlb_pkg::RETRY_EVER) &&
                    (q.tries >= undervoltage_restart_count));

  always_comb begin
    next_q = q;
    case (q.st)
      vlb_pkg::UV_IDLE: begin
        if (output_on_i && fault_i) begin
          if (undervoltage_action_select == vlb_pkg::ACT_DELAYED) begin
            next_q.st  = vlb_pkg::UV_DELAY;
            next_q.cnt = 24'(pwm_delay);
          end else if (undervoltage_action_select == vlb_pkg::ACT_NOW) begin
            next_q.st  = give_up ? vlb_pkg::UV_LATCH : vlb_pkg::UV_OFF;
            next_q.cnt = restart_wait_period;
            next_q.tries = give_up ? q.tries : q.tries + 3'h1;
          end
        end
      end
      vlb_pkg::UV_DELAY: begin
        if (!fault_i) begin
          next_q.st = vlb_pkg::UV_IDLE;
        end else if (pwm_tick_i) begin
          next_q.cnt = q.cnt - 24'h00_0001;
          if (q.cnt <= 24'h00_0001) begin
            next_q.st    = give_up ? vlb_pkg::UV_LATCH : vlb_pkg::UV_OFF;
            next_q.cnt   = restart_wait_period;
            next_q.tries = give_up ? q.tries : q.tries + 3'h1;
          end
        end
      end
      vlb_pkg::UV_OFF: begin
        next_q.cnt = q.cnt - 24'h00_0001;
        if (q.cnt <= 24'h00_0001) begin
          next_q.st = vlb_pkg::UV_IDLE;
        end
      end
      vlb_pkg::UV_LATCH: begin
        next_q.st = vlb_pkg::UV_LATCH;
      end
      default: begin
        next_q.st = vlb_pkg::UV_IDLE;
      end
    endcase
    // Commanding the output off ends any sequence and refills the budget
    if (!output_on_i) begin
      next_q.st    = vlb_pkg::UV_IDLE;
      next_q.tries = 3'h0;
      next_q.cnt   = 24'h00_0000;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{st: vlb_pkg::UV_IDLE, cnt: 24'h00_0000, tries: 3'h0};
    end else begin
      q <= next_q;
    end
  end

  assign shutdown_o = (q.st == vlb_pkg::UV_OFF) || (q.st == vlb_pkg::UV_LATCH);
  assign latched_o  = (q.st == vlb_pkg::UV_LATCH);

  AST_NOW_SHUTS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (q.st == vlb_pkg::UV_IDLE) && output_on_i && fault_i &&
    (undervoltage_action_select == vlb_pkg::ACT_NOW) |=> shutdown_o)
    else $error("Immediate action did not shut down");

  AST_IGNORE_RUNS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (q.st == vlb_pkg::UV_IDLE) && (undervoltage_action_select == vlb_pkg::ACT_IGNORE)
    |=> !shutdown_o)
    else $error("Ignore action shut the output down");

  AST_NO_RETRY_LATCH: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (q.st == vlb_pkg::UV_IDLE) && output_on_i && fault_i &&
    (undervoltage_action_select == vlb_pkg::ACT_NOW) &&
    (undervoltage_restart_count == vlb_pkg::RETRY_NONE) |=> latched_o)
    else $error("Zero restarts did not latch off");

endmodule

// file: vlb_host_model.sv
// Command host model that issues register strobes to the limit bank
`timescale 1ns/10ps
module vlb_host_model (
  input  wire logic        mclk_i,   // 50 MHz clock
  input  wire logic [15:0] rdata_i,  // Read data word
  input  wire logic        ack_i,    // Command taken
  output vlb_pkg::vlb_cmd_t cmd_o    // Command request
);
  initial cmd_o = '0;
  // One-cycle strobe, then take ack and data one cycle later
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q, output logic ok);
    @(posedge mclk_i);
    #1;
    cmd_o = '{wr: w, rd: !w, code: c, wdata: d};
    @(posedge mclk_i);
    #1;
    cmd_o = '0;
    ok = ack_i;
    q = rdata_i;
  endtask
endmodule

// file: vlb_vout_limit_bank_bench.sv
// Self-checking bench for the output-voltage limit command bank
`timescale 1ns/10ps
module vlb_vout_limit_bank_bench;
  logic                 mclk, rst_n, ack, fabs, clr, on, tick, alert_n, shut, latch;
  logic [15:0]          rdata, vcmd, vs;
  vlb_pkg::vlb_cmd_t    cmd;
  vlb_pkg::vlb_status_t status;
  int                   fails, check_count, cyc;

  vlb_vout_limit_bank #(.RISE_CYC(8)) DUT (.mclk_i(mclk), .rst_n_i(rst_n), .cmd_i(cmd),
    .cmd_rdata_o(rdata), .cmd_ack_o(ack), .format_abs_i(fabs), .vout_command_i(vcmd),
    .vout_sense_i(vs), .clear_faults_i(clr), .output_on_i(on), .pwm_tick_i(tick),
    .status_o(status), .alert_n_o(alert_n), .shutdown_o(shut), .latched_o(latch));
  vlb_host_model HOST (.mclk_i(mclk), .rdata_i(rdata), .ack_i(ack), .cmd_o(cmd));

  // ==========================================================================
  // Clock, switching tick and hang guard
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    tick <= (cyc % 4 == 0);
    if (cyc == 6000) begin
      fails++;
      stop_test();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic ea);
    logic [15:0] q;
    logic        ok;
    HOST.xfer(1'b1, c, d, q, ok);
    chk({15'h0, ok}, {15'h0, ea});
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] q;
    logic        ok;
    HOST.xfer(1'b0, c, 16'h0, q, ok);
    chk({15'h0, ok}, 16'h0001);
    chk(q, e);
  endtask
  // Status lags its cause by a cycle; notify is low whenever any bit is set
  task automatic st(input logic [5:0] e);
    tk(1);
    chk({10'h0, status}, {10'h0, e});
    chk({15'h0, alert_n}, {15'h0, e == 6'h0});
  endtask
  task automatic clrf;
    vs = 16'h03e8;
    clr = 1;
    tk(1);
    clr = 0;
    tk(1);
  endtask
  // Fault under a given action byte; m masks bits whose phase is not fixed
  task automatic resp(input logic [7:0] a, input int n, input logic [1:0] m, e);
    wr(vlb_pkg::CMD_UV_RESP, {8'h0, a}, 1'b1);
    on = 1;
    vs = 16'h0200;
    tk(n);
    chk({14'h0, {shut, latch} & m}, {14'h0, e});
    on = 0;
    tk(2);
    clrf();
  endtask

  // ==========================================================================
  // Main sequence: target 1000 in relative format
  initial begin
    fails = 0;
    check_count = 0;
    cyc = 0;
    {rst_n, fabs, clr, on} = '0;
    vcmd = 16'h03e8;
    vs = 16'h03e8;
    tk(8);
    rst_n = 1;
    st(6'h00);
    rd(vlb_pkg::CMD_OV_WARN, vlb_pkg::OVW_RST_RAW);
    rd(vlb_pkg::CMD_UV_WARN, vlb_pkg::UVW_RST_RAW);
    rd(vlb_pkg::CMD_UV_FAULT, vlb_pkg::UVF_RST_RAW);
    rd(vlb_pkg::CMD_UV_RESP, {8'h0, vlb_pkg::RESP_RST});
    vs = 16'h0468;
    st(6'h00);
    vs = 16'h046b;
    st(6'h14);
    clrf();
    vs = 16'h0368;
    st(6'h00);
    vs = 16'h0365;
    st(6'h12);
    vs = 16'h03e8;
    vcmd = 16'h07d0;
    // Doubled target lifts the fault threshold above the sense as well
    st(6'h33);
    vcmd = 16'h03e8;
    clrf();
    wr(8'h46, 16'h0001, 1'b0);
    wr(vlb_pkg::CMD_OV_WARN, 16'h0201, 1'b1);
    st(6'h08);
    rd(vlb_pkg::CMD_OV_WARN, vlb_pkg::OVW_RST_RAW);
    // 103.1 percent rounds up to 104, so the threshold sits at 1040
    wr(vlb_pkg::CMD_OV_WARN, 16'h0210, 1'b1);
    rd(vlb_pkg::CMD_OV_WARN, 16'h0210);
    vs = 16'h0410;
    st(6'h08);
    vs = 16'h0411;
    st(6'h1c);
    clrf();
    wr(vlb_pkg::CMD_UV_RESP, 16'h00c0, 1'b1);
    st(6'h08);
    clrf();
    wr(vlb_pkg::CMD_UV_WARN, 16'h01cc, 1'b1);
    rd(vlb_pkg::CMD_UV_WARN, 16'h01cc);
    vs = 16'h037f;
    st(6'h00);
    wr(vlb_pkg::CMD_UV_FAULT, 16'h0100, 1'b1);
    st(6'h08);
    clrf();
    wr(vlb_pkg::CMD_UV_FAULT, 16'h0150, 1'b1);
    vs = 16'h028b;
    st(6'h12);
    vs = 16'h0289;
    st(6'h33);
    clrf();
    fabs = 1;
    wr(vlb_pkg::CMD_UV_WARN, 16'h0384, 1'b1);
    vcmd = 16'h04b0;
    rd(vlb_pkg::CMD_UV_WARN, 16'h0384);
    {fabs, vcmd} = {1'b0, 16'h03e8};
    clrf();
    resp(8'h00, 20, 2'b11, 2'b00);
    resp(8'h80, 3, 2'b11, 2'b11);
    resp(8'h48, 40, 2'b11, 2'b11);
    resp(8'hb8, 150, 2'b01, 2'b00);
    resp(8'h45, 12, 2'b11, 2'b00);
    resp(8'h45, 34, 2'b11, 2'b11);
    stop_test();
  end
endmodule
